// ---- hdl/slfc_port.sv ----
// Link-level credit flow control for one serial link port, with AHB-Lite registers
// Functional notes
// - Transmitter-controlled mode is announced by a buffer report other than all ones.
// - Buffer report is the free maximum-size buffer count, saturated at field maximum.
// - The report may understate but never overstate the free buffers.
// - Changes of free buffers go out in accepted, retry or status symbols.
// - A buffer-carrying symbol is sent at least at the minimum symbol rate.
// - A retry symbol from the partner puts the output side into retry-stopped.
// - Input retry-stopped discards the retried packet and ignores all later packets.
// - Input retry-stopped sends a retry symbol carrying the retried packet's tag.
// - A received restart-from-retry ends input retry-stopped.
// - Output retry-stopped halts new packets and restarts acknowledgment timers.
// - Output retry-stopped sends one restart-from-retry symbol.
// - Output side rewinds to the retried packet's tag.
// - Output resumes; first packet sent carries the retried tag.
// - Optional watermarks limit allowed priorities by effective free buffers.
// - Watermarks reset to four, three, two and stay strictly ordered above zero.
// - Watermarks may be adjusted from the status report seen before transmission.
// - Watermarks and initial report sit as four 8-bit fields of one word.
// - The port counts packets sent but not yet acknowledged.
// - Accepted: in-flight minus one, effective free is report minus in-flight.
// - Retry: in-flight cleared, effective free equals the received report.
// - Not-accepted: both cleared, link-request sent, free loaded from response.
// - Packets beyond effective free buffers may be sent speculatively.
// - After link initialization status symbols advertise the supported mode.
// - Transmitter-controlled mode only when both ports support it.
// - Receiver-controlled mode reports all ones in every buffer field.
// - Packets are accepted only in consecutive tag order modulo 32.
`default_nettype none
`include "slfc_regs.svh"
module slfc_port (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Link state and local receive buffers
  input  wire logic              link_init,
  input  wire logic [5:0]        local_free_bufs,
  // Received control symbols
  input  wire logic              rx_sym_valid,
  input  wire slfc_pkg::slfc_sym_e rx_sym_type,
  input  wire logic [4:0]        rx_sym_tag,
  input  wire logic [4:0]        rx_sym_buf,
  // Control symbols to send
  output logic                   tx_sym_valid,
  input  wire logic              tx_sym_ready,
  output slfc_pkg::slfc_sym_e    tx_sym_type,
  output logic [4:0]             tx_sym_tag,
  output logic [4:0]             tx_sym_buf,
  // Received packets (error-free, end of packet)
  input  wire logic              rx_pkt_valid,
  output logic                   rx_pkt_ready,
  input  wire logic [4:0]        rx_pkt_tag,
  input  wire logic [1:0]        rx_pkt_prio,
  output logic                   rx_pkt_take,
  // Packets to send
  input  wire logic              tx_pkt_valid,
  output logic                   tx_pkt_ready,
  input  wire logic [1:0]        tx_pkt_prio,
  output logic [4:0]             tx_pkt_tag,
  output logic                   tx_rewind,
  output logic                   ack_timer_restart
);

  // ===========================================================
  // Event decode
  logic rx_acc, rx_rty, rx_nac, rx_sts, rx_rst, rx_rsp;
  assign rx_acc = rx_sym_valid && (rx_sym_type == slfc_pkg::SYM_ACCEPTED);
  assign rx_rty = rx_sym_valid && (rx_sym_type == slfc_pkg::SYM_RETRY);
  assign rx_nac = rx_sym_valid && (rx_sym_type == slfc_pkg::SYM_NOT_ACC);
  assign rx_sts = rx_sym_valid && (rx_sym_type == slfc_pkg::SYM_STATUS);
  assign rx_rst = rx_sym_valid && (rx_sym_type == slfc_pkg::SYM_RESTART);
  assign rx_rsp = rx_sym_valid && (rx_sym_type == slfc_pkg::SYM_LINK_RESP);

  // ===========================================================
  // Registers and their next values
  logic [2:0]  ctrl_q, ctrl_d;
  logic [4:0]  wm_hi_q, wm_hi_d, wm_mid_q, wm_mid_d, wm_lo_q, wm_lo_d;
  logic [4:0]  init_buf_q, init_buf_d;
  logic        dph_wr_q, dph_wr_d;
  logic [7:0]  dph_addr_q, dph_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        link_up_q, link_up_d, pre_tx_q, pre_tx_d, partner_q, partner_d;
  logic [4:0]  buf_rep_q, buf_rep_d;
  logic [9:0]  per_cnt_q, per_cnt_d;
  logic        pend_acc_q, pend_acc_d, pend_rty_q, pend_rty_d;
  logic        pend_rst_q, pend_rst_d, pend_lrq_q, pend_lrq_d, pend_sts_q, pend_sts_d;
  logic [4:0]  acc_tag_q, acc_tag_d, rty_tag_q, rty_tag_d;
  logic        in_stop_q, in_stop_d, take_q, take_d;
  logic [4:0]  exp_tag_q, exp_tag_d;
  slfc_pkg::slfc_out_e out_q, out_d;
  logic [4:0]  next_tag_q, next_tag_d;
  logic [5:0]  outst_q, outst_d, free_q, free_d;
  logic        rewind_q, rewind_d, tmr_q, tmr_d, heard_q, heard_d;

  logic        tx_mode, adv, pkt_in, room, pkt_send, sym_sent, buf_sym;
  logic [3:0]  prio_ok;
  logic [4:0]  wr_hi, wr_mid, wr_lo;

  // Both ends must support it, else both fall back
  assign tx_mode = ctrl_q[`SLFC_CTRL_TXC_BIT] && partner_q;
  // Own support is advertised until the partner's status has been heard
  assign adv = ctrl_q[`SLFC_CTRL_TXC_BIT] && (partner_q || !heard_q);

  // ===========================================================
  // Bus slave: zero wait state, read data captured in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wr_hi     = hwdata[`SLFC_WM_HIGH_LSB +: 5];
  assign wr_mid    = hwdata[`SLFC_WM_MID_LSB +: 5];
  assign wr_lo     = hwdata[`SLFC_WM_LOW_LSB +: 5];

  always_comb
  begin
    ctrl_d     = ctrl_q;
    wm_hi_d    = wm_hi_q;
    wm_mid_d   = wm_mid_q;
    wm_lo_d    = wm_lo_q;
    dph_wr_d   = 1'b0;
    dph_addr_d = dph_addr_q;
    hrdata_d   = hrdata_q;
    if (hsel && htrans[1] && hready)
    begin
      dph_wr_d   = hwrite;
      dph_addr_d = haddr[7:0];
      case (haddr[7:0])
        `SLFC_ADDR_CTRL:   hrdata_d = {29'h0000_0000, ctrl_q};
        `SLFC_ADDR_STATUS: hrdata_d = {15'h0000, outst_q, free_q, out_q,
                                       in_stop_q, partner_q, tx_mode};
        `SLFC_ADDR_WM:     hrdata_d = {3'h0, init_buf_q, 3'h0, wm_lo_q,
                                       3'h0, wm_mid_q, 3'h0, wm_hi_q};
        default:           hrdata_d = 32'h0000_0000;
      endcase
    end
    if (dph_wr_q)
    begin
      if (dph_addr_q == `SLFC_ADDR_CTRL)
        ctrl_d = hwdata[2:0];
      // A write that breaks the ordering or range is dropped whole
      if (dph_addr_q == `SLFC_ADDR_WM && wr_hi > wr_mid && wr_mid > wr_lo
          && wr_lo != 5'h00 && wr_hi <= `SLFC_FIELD_MAX)
      begin
        wm_hi_d  = wr_hi;
        wm_mid_d = wr_mid;
        wm_lo_d  = wr_lo;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q     <= `SLFC_CTRL_RST;
      wm_hi_q    <= `SLFC_WM_HIGH_RST;
      wm_mid_q   <= `SLFC_WM_MID_RST;
      wm_lo_q    <= `SLFC_WM_LOW_RST;
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 8'h00;
      hrdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      wm_hi_q    <= wm_hi_d;
      wm_mid_q   <= wm_mid_d;
      wm_lo_q    <= wm_lo_d;
      dph_wr_q   <= dph_wr_d;
      dph_addr_q <= dph_addr_d;
      hrdata_q   <= hrdata_d;
    end
  end

  // ===========================================================
  // Priority gating by watermarks
  always_comb
  begin
    prio_ok = 4'hF;
    // Speculative sending lifts the limit; the partner retries the excess
    if (tx_mode && ctrl_q[`SLFC_CTRL_WM_BIT] && !ctrl_q[`SLFC_CTRL_SPEC_BIT])
    begin
      if (free_q >= {1'b0, wm_hi_q})
        prio_ok = 4'hF;
      else if (free_q >= {1'b0, wm_mid_q})
        prio_ok = 4'hE;
      else if (free_q >= {1'b0, wm_lo_q})
        prio_ok = 4'hC;
      else
        prio_ok = 4'h8;
    end
  end

  // A retry or not-accepted arriving now would void a packet started now
  assign tx_pkt_ready = link_up_q && (out_q == slfc_pkg::OUT_RUN) && !rx_rty && !rx_nac
                        && prio_ok[tx_pkt_prio];
  assign pkt_send     = tx_pkt_valid && tx_pkt_ready;
  assign tx_pkt_tag   = next_tag_q;
  assign tx_rewind    = rewind_q;
  assign ack_timer_restart = tmr_q;

  // ===========================================================
  // Symbol selection: retry first, so the partner stops soonest
  assign tx_sym_valid = pend_rty_q || pend_rst_q || pend_lrq_q || pend_acc_q || pend_sts_q;
  assign tx_sym_buf   = buf_rep_q;
  always_comb
  begin
    tx_sym_type = slfc_pkg::SYM_STATUS;
    tx_sym_tag  = 5'h00;
    if (pend_rty_q)
    begin
      tx_sym_type = slfc_pkg::SYM_RETRY;
      tx_sym_tag  = rty_tag_q;
    end
    else if (pend_rst_q)
      tx_sym_type = slfc_pkg::SYM_RESTART;
    else if (pend_lrq_q)
      tx_sym_type = slfc_pkg::SYM_LINK_REQ;
    else if (pend_acc_q)
    begin
      tx_sym_type = slfc_pkg::SYM_ACCEPTED;
      tx_sym_tag  = acc_tag_q;
    end
  end
  assign sym_sent = tx_sym_valid && tx_sym_ready;
  assign buf_sym  = sym_sent && (pend_rty_q || (!pend_rst_q && !pend_lrq_q));

  // ===========================================================
  // Input side
  assign rx_pkt_ready = !pend_acc_q && !pend_rty_q;
  assign rx_pkt_take  = take_q;
  assign pkt_in       = rx_pkt_valid && rx_pkt_ready;
  // Lower priorities need spare buffers so the highest priority can pass while any buffer is free
  assign room = local_free_bufs > {4'h0, 2'h3 - rx_pkt_prio};

  // ===========================================================
  // Protocol state next values
  always_comb
  begin
    link_up_d  = link_up_q;
    pre_tx_d   = pre_tx_q;
    partner_d  = partner_q;
    init_buf_d = init_buf_q;
    per_cnt_d  = per_cnt_q + 10'h001;
    pend_acc_d = pend_acc_q && !(sym_sent && !pend_rty_q && !pend_rst_q && !pend_lrq_q);
    pend_rty_d = pend_rty_q && !sym_sent;
    pend_rst_d = pend_rst_q && !(sym_sent && !pend_rty_q);
    pend_lrq_d = pend_lrq_q && !(sym_sent && !pend_rty_q && !pend_rst_q);
    pend_sts_d = pend_sts_q && !buf_sym;
    acc_tag_d  = acc_tag_q;
    rty_tag_d  = rty_tag_q;
    in_stop_d  = in_stop_q;
    take_d     = 1'b0;
    exp_tag_d  = exp_tag_q;
    out_d      = out_q;
    next_tag_d = next_tag_q;
    outst_d    = outst_q;
    free_d     = free_q;
    rewind_d   = 1'b0;
    tmr_d      = 1'b0;
    heard_d    = heard_q || rx_sts;
    // Report: all ones in receiver-controlled mode, else saturated count
    if (!adv)
      buf_rep_d = `SLFC_BUF_ALL_ONES;
    else if (local_free_bufs > {1'b0, `SLFC_FIELD_MAX})
      buf_rep_d = `SLFC_FIELD_MAX;
    else
      buf_rep_d = local_free_bufs[4:0];
    // Change and periodic triggers set the status request; set wins over clear
    if (link_up_q && (buf_rep_d != buf_rep_q || per_cnt_q == `SLFC_STATUS_LAST))
      pend_sts_d = 1'b1;
    if (buf_sym)
      per_cnt_d = 10'h000;

    if (link_init)
    begin
      link_up_d  = 1'b1;
      pre_tx_d   = 1'b1;
      heard_d    = 1'b0;
      pend_sts_d = 1'b1;
      outst_d    = 6'h00;
      free_d     = 6'h00;
      out_d      = slfc_pkg::OUT_RUN;
    end
    else
    begin
      if (rx_sts)
        partner_d = rx_sym_buf != `SLFC_BUF_ALL_ONES;
      if (rx_sts && pre_tx_q)
      begin
        init_buf_d = rx_sym_buf;
        free_d     = {1'b0, rx_sym_buf};
      end

      // Input side: accept in tag order, retry when out of room
      if (rx_rst)
        in_stop_d = 1'b0;
      if (pkt_in && !in_stop_q && rx_pkt_tag == exp_tag_q)
      begin
        if (room)
        begin
          pend_acc_d = 1'b1;
          acc_tag_d  = rx_pkt_tag;
          take_d     = 1'b1;
          exp_tag_d  = exp_tag_q + 5'h01;
        end
        else
        begin
          in_stop_d  = 1'b1;
          pend_rty_d = 1'b1;
          rty_tag_d  = rx_pkt_tag;
        end
      end

      // Output side recovery and credit tracking
      if (rx_rty)
      begin
        out_d      = slfc_pkg::OUT_STOP;
        tmr_d      = 1'b1;
        pend_rst_d = 1'b1;
        next_tag_d = rx_sym_tag;
        rewind_d   = 1'b1;
        outst_d    = 6'h00;
        free_d     = {1'b0, rx_sym_buf};
      end
      else if (rx_nac)
      begin
        outst_d    = 6'h00;
        free_d     = 6'h00;
        pend_lrq_d = 1'b1;
        out_d      = slfc_pkg::OUT_LRQ;
      end
      else if (rx_rsp && out_q == slfc_pkg::OUT_LRQ)
      begin
        free_d = {1'b0, rx_sym_buf};
        out_d  = slfc_pkg::OUT_RUN;
      end
      else if (rx_acc)
      begin
        if (outst_q != 6'h00)
          outst_d = outst_q - 6'h01;
        if (outst_d > {1'b0, rx_sym_buf})
          free_d = 6'h00;
        else
          free_d = {1'b0, rx_sym_buf} - outst_d;
      end
      // Leave stop once the restart symbol is out
      if (out_q == slfc_pkg::OUT_STOP && sym_sent && !pend_rty_q && pend_rst_q)
        out_d = slfc_pkg::OUT_RUN;

      if (pkt_send)
      begin
        pre_tx_d   = 1'b0;
        outst_d    = outst_d + 6'h01;
        if (free_d != 6'h00)
          free_d = free_d - 6'h01;
        next_tag_d = next_tag_q + 5'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link_up_q  <= 1'b0;
      pre_tx_q   <= 1'b0;
      partner_q  <= 1'b0;
      init_buf_q <= 5'h00;
      buf_rep_q  <= `SLFC_BUF_ALL_ONES;
      per_cnt_q  <= 10'h000;
      pend_acc_q <= 1'b0;
      pend_rty_q <= 1'b0;
      pend_rst_q <= 1'b0;
      pend_lrq_q <= 1'b0;
      pend_sts_q <= 1'b0;
      acc_tag_q  <= 5'h00;
      rty_tag_q  <= 5'h00;
      in_stop_q  <= 1'b0;
      take_q     <= 1'b0;
      exp_tag_q  <= 5'h00;
      out_q      <= slfc_pkg::OUT_RUN;
      next_tag_q <= 5'h00;
      outst_q    <= 6'h00;
      free_q     <= 6'h00;
      rewind_q   <= 1'b0;
      tmr_q      <= 1'b0;
      heard_q    <= 1'b0;
    end
    else
    begin
      link_up_q  <= link_up_d;
      pre_tx_q   <= pre_tx_d;
      partner_q  <= partner_d;
      init_buf_q <= init_buf_d;
      buf_rep_q  <= buf_rep_d;
      per_cnt_q  <= per_cnt_d;
      pend_acc_q <= pend_acc_d;
      pend_rty_q <= pend_rty_d;
      pend_rst_q <= pend_rst_d;
      pend_lrq_q <= pend_lrq_d;
      pend_sts_q <= pend_sts_d;
      acc_tag_q  <= acc_tag_d;
      rty_tag_q  <= rty_tag_d;
      in_stop_q  <= in_stop_d;
      take_q     <= take_d;
      exp_tag_q  <= exp_tag_d;
      out_q      <= out_d;
      next_tag_q <= next_tag_d;
      outst_q    <= outst_d;
      free_q     <= free_d;
      rewind_q   <= rewind_d;
      tmr_q      <= tmr_d;
      heard_q    <= heard_d;
    end
  end

  // ===========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_retry_in;
    pkt_in && !in_stop_q && rx_pkt_tag == exp_tag_q && !room && !link_init;
  endsequence

  a_rc_all_ones: assert property (tx_sym_valid && !adv && !$past(adv, 1) |->
    tx_sym_buf == `SLFC_BUF_ALL_ONES) else $error("report not all ones");
  a_report_bound: assert property (tx_mode |=> buf_rep_q == `SLFC_BUF_ALL_ONES ||
    {1'b0, buf_rep_q} <= $past(local_free_bufs)) else $error("report too high");
  a_out_stop: assert property (rx_rty && !link_init |=> out_q == slfc_pkg::OUT_STOP
    && !tx_pkt_ready && tmr_q && next_tag_q == $past(rx_sym_tag))
    else $error("retry stop wrong");
  a_in_retry_tag: assert property (s_retry_in |=> in_stop_q && tx_sym_valid
    && tx_sym_type == slfc_pkg::SYM_RETRY && tx_sym_tag == $past(rx_pkt_tag))
    else $error("retry symbol wrong");
  a_in_ignore: assert property (in_stop_q && !rx_rst && !link_init |=> $stable(exp_tag_q)
    && !take_q) else $error("packet taken while stopped");
  a_in_exit: assert property (rx_rst && !link_init |=> !in_stop_q)
    else $error("restart did not exit");
  a_tag_order: assert property (take_q |-> exp_tag_q == $past(exp_tag_q) + 5'h01)
    else $error("tag order broken");
  a_acc_count: assert property (rx_acc && !rx_rty && !link_init && !pkt_send
    && outst_q != 6'h00 |=> outst_q == $past(outst_q) - 6'h01)
    else $error("in-flight not reduced");
  a_retry_credit: assert property (rx_rty && !link_init |=> outst_q == 6'h00
    && free_q == {1'b0, $past(rx_sym_buf)}) else $error("retry credit wrong");
  a_nack_seq: assert property (rx_nac && !rx_rty && !link_init |=> outst_q == 6'h00
    && free_q == 6'h00 && out_q == slfc_pkg::OUT_LRQ && tx_sym_valid)
    else $error("not-accepted handling wrong");
  a_prio_low: assert property (tx_pkt_ready && tx_mode && ctrl_q[`SLFC_CTRL_WM_BIT]
    && !ctrl_q[`SLFC_CTRL_SPEC_BIT] && free_q < {1'b0, wm_lo_q} |-> tx_pkt_prio == 2'h3)
    else $error("priority gate wrong");

endmodule : slfc_port
`default_nettype wire

// ---- hdl/slfc_regs.svh ----
// Register offsets, field positions, reset values and counts of the link flow-control port
`ifndef SLFC_REGS_SVH
`define SLFC_REGS_SVH

// =============================================================
// Register byte offsets (AHB-Lite, one aligned word each)
`define SLFC_ADDR_CTRL      8'h00
`define SLFC_ADDR_STATUS    8'h04
`define SLFC_ADDR_WM        8'h08

// =============================================================
// Control register fields
`define SLFC_CTRL_TXC_BIT   0
`define SLFC_CTRL_WM_BIT    1
`define SLFC_CTRL_SPEC_BIT  2
`define SLFC_CTRL_RST       3'h3

// =============================================================
// Watermark / configuration-status word fields
`define SLFC_WM_HIGH_LSB    0
`define SLFC_WM_MID_LSB     8
`define SLFC_WM_LOW_LSB     16
`define SLFC_WM_INIT_LSB    24
`define SLFC_WM_HIGH_RST    5'h04
`define SLFC_WM_MID_RST     5'h03
`define SLFC_WM_LOW_RST     5'h02
`define SLFC_FIELD_MAX      5'h1E

// =============================================================
// Buffer report and timing
`define SLFC_BUF_ALL_ONES   5'h1F
`define SLFC_STATUS_LAST    10'h3FF

`endif

// ---- hdl/slfc_pkg.sv ----
// Types shared by the link flow-control port
`default_nettype none
package slfc_pkg;
  // Control symbol kinds exchanged with the link partner
  typedef enum logic [2:0] {
    SYM_ACCEPTED,
    SYM_RETRY,
    SYM_NOT_ACC,
    SYM_STATUS,
    SYM_RESTART,
    SYM_LINK_REQ,
    SYM_LINK_RESP
  } slfc_sym_e;

  // Output side recovery states
  typedef enum logic [1:0] {
    OUT_RUN,
    OUT_STOP,
    OUT_LRQ
  } slfc_out_e;
endpackage : slfc_pkg
`default_nettype wire

// ---- testbench/slfc_partner.sv ----
// Link partner model that takes control symbols from the port, promptly or with stalls
`default_nettype none
module slfc_partner (
  // Clock and pacing
  input  wire logic                hclk,
  input  wire logic                slow,
  // Control symbols from the port
  input  wire logic                tx_sym_valid,
  output logic                     tx_sym_ready,
  input  wire slfc_pkg::slfc_sym_e tx_sym_type,
  input  wire logic [4:0]          tx_sym_tag,
  input  wire logic [4:0]          tx_sym_buf
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt    [8];
  logic [4:0]  tag_of [8];
  logic [4:0]  buf_of [8];
  initial tx_sym_ready = 1'b0;
  // =============================================
  // Symbol intake
  // Stalls every other cycle when slow, so the port must hold each symbol
  always @(posedge hclk)
  begin
    tx_sym_ready <= slow ? ~tx_sym_ready : 1'b1;
    if (tx_sym_valid === 1'b1 && tx_sym_ready === 1'b1)
    begin
      cnt[tx_sym_type]    <= cnt[tx_sym_type] + 1;
      tag_of[tx_sym_type] <= tx_sym_tag;
      buf_of[tx_sym_type] <= tx_sym_buf;
    end
  end
endmodule : slfc_partner
`default_nettype wire

// ---- testbench/slfc_port_tb.sv ----
// Self-checking bench of the link flow-control port
`default_nettype none
`include "slfc_regs.svh"
module slfc_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, link_init = 0;
  logic                slow = 0, rx_sym_valid = 0, rx_pkt_valid = 0, tx_pkt_valid = 0;
  logic [31:0]         haddr = 0, hwdata = 0, sreg, q;
  logic [1:0]          htrans = 0, rx_pkt_prio = 0, tx_pkt_prio = 3;
  logic [5:0]          local_free_bufs = 6;
  logic [4:0]          rx_sym_tag = 0, rx_sym_buf = 0, rx_pkt_tag = 0;
  slfc_pkg::slfc_sym_e rx_sym_type = slfc_pkg::SYM_ACCEPTED;
  logic                hreadyout, hresp, tx_sym_valid, tx_sym_ready, rx_pkt_ready;
  logic                rx_pkt_take, tx_pkt_ready, tx_rewind, ack_timer_restart;
  logic [31:0]         hrdata;
  slfc_pkg::slfc_sym_e tx_sym_type;
  logic [4:0]          tx_sym_tag, tx_sym_buf, tx_pkt_tag;
  int                  fails = 0, checks = 0, c;

  slfc_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .link_init, .local_free_bufs,
    .rx_sym_valid, .rx_sym_type, .rx_sym_tag, .rx_sym_buf, .tx_sym_valid, .tx_sym_ready,
    .tx_sym_type, .tx_sym_tag, .tx_sym_buf, .rx_pkt_valid, .rx_pkt_ready, .rx_pkt_tag,
    .rx_pkt_prio, .rx_pkt_take, .tx_pkt_valid, .tx_pkt_ready, .tx_pkt_prio, .tx_pkt_tag,
    .tx_rewind, .ack_timer_restart);
  slfc_partner p (.hclk, .slow, .tx_sym_valid, .tx_sym_ready, .tx_sym_type, .tx_sym_tag,
    .tx_sym_buf);

  always #5 hclk = ~hclk;

  // =============================================
  // Bench tasks
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0000_00, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rd

  task automatic rs;
    bus(1'b0, `SLFC_ADDR_STATUS, 32'h0000_0000);
    sreg = q;
  endtask : rs

  task automatic sym(input slfc_pkg::slfc_sym_e t, input logic [4:0] tg, input logic [4:0] bf);
    @(posedge hclk);
    rx_sym_valid <= 1'b1; rx_sym_type <= t; rx_sym_tag <= tg; rx_sym_buf <= bf;
    @(posedge hclk);
    rx_sym_valid <= 1'b0;
  endtask : sym

  task automatic wsym(input slfc_pkg::slfc_sym_e t, input int n);
    while (p.cnt[t] == n) @(posedge hclk);
  endtask : wsym

  task automatic rxp(input logic [4:0] tg, input logic take);
    @(posedge hclk);
    rx_pkt_valid <= 1'b1; rx_pkt_tag <= tg; rx_pkt_prio <= 2'b00;
    do @(posedge hclk); while (rx_pkt_ready !== 1'b1);
    rx_pkt_valid <= 1'b0;
    @(posedge hclk);
    chk(rx_pkt_take, take);
  endtask : rxp

  task automatic txp(input int n);
    @(posedge hclk);
    tx_pkt_valid <= 1'b1; tx_pkt_prio <= 2'b11;
    while (n > 0)
    begin
      @(posedge hclk);
      if (tx_pkt_ready === 1'b1) n--;
    end
    tx_pkt_valid <= 1'b0;
    @(posedge hclk);
  endtask : txp

  // =============================================
  // Watchdog, well beyond the longest expected run
  initial
  begin
    repeat (20000) @(posedge hclk);
    fails++;
    end_sim();
  end

  // =============================================
  // Test sequence
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SLFC_ADDR_CTRL, 32'h0000_0003);
    rd(`SLFC_ADDR_WM, 32'h0002_0304);
    rd(8'h0C, 32'h0000_0000);
    bus(1'b1, `SLFC_ADDR_WM, 32'h0003_0304);
    rd(`SLFC_ADDR_WM, 32'h0002_0304);
    bus(1'b1, `SLFC_ADDR_WM, 32'h1103_0506);
    rd(`SLFC_ADDR_WM, 32'h0003_0506);
    @(posedge hclk) link_init <= 1'b1;
    @(posedge hclk) link_init <= 1'b0;
    wsym(slfc_pkg::SYM_STATUS, 0);
    chk(p.buf_of[slfc_pkg::SYM_STATUS] <= 5'd6, 1);
    chk(p.buf_of[slfc_pkg::SYM_STATUS] != 5'h1F, 1);
    sym(slfc_pkg::SYM_STATUS, 5'd0, 5'd10);
    rs();
    chk(sreg[1:0], 2'b11);
    txp(3);
    chk(tx_pkt_tag, 5'd3);
    rs();
    chk(sreg[16:11], 6'd3);
    sym(slfc_pkg::SYM_ACCEPTED, 5'd0, 5'd8);
    rs();
    chk(sreg[16:5], {6'd2, 6'd6});
    c = p.cnt[slfc_pkg::SYM_RESTART];
    sym(slfc_pkg::SYM_RETRY, 5'd1, 5'd7);
    @(posedge hclk);
    chk({tx_rewind, ack_timer_restart, tx_pkt_ready}, 3'b110);
    chk(tx_pkt_tag, 5'd1);
    wsym(slfc_pkg::SYM_RESTART, c);
    rs();
    chk(p.cnt[slfc_pkg::SYM_RESTART], c + 1);
    chk(sreg[16:3], {6'd0, 6'd7, 2'd0});
    txp(1);
    chk(tx_pkt_tag, 5'd2);
    rs();
    chk(sreg[10:5], 6'd6);
    c = p.cnt[slfc_pkg::SYM_LINK_REQ];
    sym(slfc_pkg::SYM_NOT_ACC, 5'd0, 5'd0);
    rs();
    chk(sreg[16:3], {6'd0, 6'd0, 2'd2});
    wsym(slfc_pkg::SYM_LINK_REQ, c);
    sym(slfc_pkg::SYM_LINK_RESP, 5'd0, 5'd2);
    rs();
    chk(sreg[10:3], {6'd2, 2'd0});
    @(posedge hclk) tx_pkt_prio <= 2'b00;
    @(posedge hclk) chk(tx_pkt_ready, 1'b0);
    tx_pkt_prio <= 2'b11;
    @(posedge hclk) chk(tx_pkt_ready, 1'b1);
    slow <= 1'b1;
    c = p.cnt[slfc_pkg::SYM_ACCEPTED];
    rxp(5'd0, 1'b1);
    wsym(slfc_pkg::SYM_ACCEPTED, c);
    chk(p.tag_of[slfc_pkg::SYM_ACCEPTED], 5'd0);
    chk(p.buf_of[slfc_pkg::SYM_ACCEPTED] <= 5'd6, 1);
    rxp(5'd5, 1'b0);
    local_free_bufs <= 6'd0;
    c = p.cnt[slfc_pkg::SYM_RETRY];
    rxp(5'd1, 1'b0);
    wsym(slfc_pkg::SYM_RETRY, c);
    chk(p.tag_of[slfc_pkg::SYM_RETRY], 5'd1);
    local_free_bufs <= 6'd6;
    rs();
    chk(sreg[2], 1'b1);
    rxp(5'd1, 1'b0);
    sym(slfc_pkg::SYM_RESTART, 5'd0, 5'd0);
    rs();
    chk(sreg[2], 1'b0);
    rxp(5'd1, 1'b1);
    bus(1'b1, `SLFC_ADDR_CTRL, 32'h0000_0002);
    c = p.cnt[slfc_pkg::SYM_STATUS];
    wsym(slfc_pkg::SYM_STATUS, c);
    chk(p.buf_of[slfc_pkg::SYM_STATUS], 5'h1F);
    rs();
    chk(sreg[0], 1'b0);
    end_sim();
  end
endmodule : slfc_port_tb
`default_nettype wire
